/* include/bal_params.svh */
/*
 Register offsets, field positions, reset values and interrupt layout of the bridge audio/link
 status block. Assumes an 8-bit register port with byte-index addresses.
*/
// Contract
// - TDM enable carries input audio as TDM
// - Source select: 0 embedded, 1 local I2S
// - Aux enable adds a 2-channel audio stream
// - Aux enable loaded from strap at power-up
// - Bit 7 enables TDM-to-parallel converter clock
// - I2S output only when source is embedded
// - Bit 3: FIFO reset on audio type change
// - Bit 2: FIFO reset on audio infoframe change
// - Bit 1: FIFO reset on video infoframe change
// - Bit 0: FIFO reset on N/CTS change
// - Status bit 7 shows downstream ready
// - Bit 6 transmit active, only when valid
// - Bits 5:4 report port mode while transmitting
// - Bit 3 shows symbols recovered
// - Bit 2 shows input PLL locked
// - Bit 1 shows no input clock
// - Bit 0 shows frequency settled
`ifndef BAL_PARAMS_SVH
`define BAL_PARAMS_SVH

`define BAL_ADDR_BRIDGE_CONTROL 8'h54
`define BAL_ADDR_AUDIO_SETTINGS 8'h55
`define BAL_ADDR_LINK_STATE 8'h5a
`define BAL_ADDR_IRQ_STATUS 8'h60
`define BAL_ADDR_IRQ_MASK 8'h61

`define BAL_BC_TDM_EN 2
`define BAL_BC_SRC_SEL 1
`define BAL_BC_AUX_EN 0
`define BAL_BC_MASK 8'h07

`define BAL_AS_TDM_PAR 7
`define BAL_AS_I2S_OUT 6
`define BAL_AS_RST_TYPE 3
`define BAL_AS_RST_AIF 2
`define BAL_AS_RST_AVI 1
`define BAL_AS_RST_ACR 0
`define BAL_AS_MASK 8'hcf
`define BAL_AS_RESET 8'h0c
`define BAL_BC_RESET 8'h00
`define BAL_LS_RESET 8'h00

// Interrupt status bits
`define BAL_IRQ_FIFO_RST 0
`define BAL_IRQ_LINK_UP 1
`define BAL_IRQ_LINK_DOWN 2
`define BAL_IRQ_CLK_LOST 3
`define BAL_IRQ_W 4

`endif

/* include/bal_pkg.sv */
/*
 Types of the bridge audio/link status block. Assumes bal_params.svh for numeric constants.
*/
package bal_pkg;
    typedef logic [7:0] bal_byte_t;
    typedef logic [1:0] bal_port_mode_t;
endpackage : bal_pkg

/* core/bal_regs.sv */
/*
 Bridge control, audio settings and link/input status registers with FIFO auto-reset triggers
 and a masked interrupt. Assumes all status inputs are asynchronous to sys_clk_i and the strap
 pin is stable around reset release.
*/
`timescale 1ns/100ps
`include "bal_params.svh"

module bal_regs (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire bal_pkg::bal_byte_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output bal_pkg::bal_byte_t reg_rdata_o,
    // Strap
    input wire logic strap_select_zero_i,
    // Link and input status pins
    input wire logic downstream_ready_i,
    input wire logic serial_tx_on_i,
    input wire logic remote_locked_i,
    input wire logic mode_correct_i,
    input wire bal_pkg::bal_port_mode_t serial_port_mode_i,
    input wire logic input_symbols_recovered_i,
    input wire logic input_pll_locked_i,
    input wire logic input_clock_absent_i,
    input wire logic input_frequency_settled_i,
    // Audio change events, levels toggling per change
    input wire logic audio_type_tgl_i,
    input wire logic audio_infoframe_tgl_i,
    input wire logic video_infoframe_tgl_i,
    input wire logic clock_regen_tgl_i,
    // Audio path controls
    output logic tdm_audio_en_o,
    output logic local_audio_sel_o,
    output logic aux_audio_en_o,
    output logic tdm_to_parallel_en_o,
    output logic converter_clk_sel_o,
    output logic i2s_out_en_o,
    output logic audio_fifo_reset_o,
    // Interrupt
    output logic irq_o
);
    import bal_pkg::*;

    localparam int NS = 13;

    // Positions inside the synchronised pin image
    localparam int SY_STRAP = 12;
    localparam int SY_READY = 11;
    localparam int SY_TX = 10;
    localparam int SY_LOCKED = 9;
    localparam int SY_MODE = 8;
    localparam int SY_PORT_HI = 7;
    localparam int SY_PORT_LO = 6;
    localparam int SY_SYMBOLS = 5;
    localparam int SY_PLL = 4;
    localparam int SY_ABSENT = 3;
    localparam int SY_SETTLED = 2;
    localparam int SY_TYPE = 1;

    // Event order inside the change detector, matching the enable bits
    localparam int EV_TYPE = 3;
    localparam int EV_AIF = 2;
    localparam int EV_AVI = 1;
    localparam int EV_ACR = 0;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic strap_taken;
        bal_byte_t bridge;
        bal_byte_t audio;
        logic [NS-1:0] s1;
        logic [NS-1:0] s2;
        logic [3:0] ev_prev;
        logic fifo_rst;
        logic [`BAL_IRQ_W-1:0] irq_sts;
        logic [`BAL_IRQ_W-1:0] irq_msk;
        logic ready_prev;
        logic clk_absent_prev;
        bal_byte_t rdata;
    } bal_state_t;

    bal_state_t st_q;
    bal_state_t st_d;
    logic rst_n;
    logic [NS-1:0] raw;
    logic tx_ok;
    bal_byte_t link_state;
    logic [3:0] ev_now;
    logic [3:0] ev_chg;
    logic [3:0] ev_en;
    logic [`BAL_IRQ_W-1:0] irq_set;
    logic [`BAL_IRQ_W-1:0] irq_clr;

    // Named views of the synchronised pin image
    logic sy_strap;
    logic sy_ready;
    logic sy_tx;
    logic sy_locked;
    logic sy_mode;
    bal_port_mode_t sy_port;
    logic sy_symbols;
    logic sy_pll;
    logic sy_absent;
    logic sy_settled;
    logic sy_type_tgl;
    bal_port_mode_t port_mode;

    // Register address decode
    logic hit_bc;
    logic hit_as;
    logic hit_ls;
    logic hit_is;
    logic hit_im;

    // Interrupt source events
    logic link_rise;
    logic link_fall;
    logic clk_loss;

    // Three further event toggles share a second synchroniser bank
    logic [2:0] ev_s1_q;
    logic [2:0] ev_s2_q;
    logic [2:0] ev_sync2;

    // Reset release synchroniser; its own flops use the raw reset
    logic [1:0] rst_sq;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sq <= 2'h0;
        end else begin
            rst_sq <= {rst_sq[0], 1'b1};
        end
    end
    assign rst_n = rst_sq[1];

    // Every asynchronous level but the three event toggles of the second bank enters through s1, logic reads only s2
    assign raw = {strap_select_zero_i,
                  downstream_ready_i,
                  serial_tx_on_i,
                  remote_locked_i,
                  mode_correct_i,
                  serial_port_mode_i,
                  input_symbols_recovered_i,
                  input_pll_locked_i,
                  input_clock_absent_i,
                  input_frequency_settled_i,
                  audio_type_tgl_i,
                  1'b0};

    assign sy_strap = st_q.s2[SY_STRAP];
    assign sy_ready = st_q.s2[SY_READY];
    assign sy_tx = st_q.s2[SY_TX];
    assign sy_locked = st_q.s2[SY_LOCKED];
    assign sy_mode = st_q.s2[SY_MODE];
    assign sy_port = st_q.s2[SY_PORT_HI:SY_PORT_LO];
    assign sy_symbols = st_q.s2[SY_SYMBOLS];
    assign sy_pll = st_q.s2[SY_PLL];
    assign sy_absent = st_q.s2[SY_ABSENT];
    assign sy_settled = st_q.s2[SY_SETTLED];
    assign sy_type_tgl = st_q.s2[SY_TYPE];

    assign hit_bc = (reg_addr_i == `BAL_ADDR_BRIDGE_CONTROL);
    assign hit_as = (reg_addr_i == `BAL_ADDR_AUDIO_SETTINGS);
    assign hit_ls = (reg_addr_i == `BAL_ADDR_LINK_STATE);
    assign hit_is = (reg_addr_i == `BAL_ADDR_IRQ_STATUS);
    assign hit_im = (reg_addr_i == `BAL_ADDR_IRQ_MASK);

    always_comb begin
        st_d = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;

        // Transmit status needs active transmitter, locked receiver, valid input and mode
        tx_ok = sy_tx & sy_locked & sy_mode & sy_symbols;

        // Port mode means nothing while not transmitting, so it reads zero
        port_mode = tx_ok ? sy_port : 2'h0;

        link_state = 8'h00;
        link_state[7] = sy_ready;
        link_state[6] = tx_ok;
        link_state[5:4] = port_mode;
        link_state[3] = sy_symbols;
        link_state[2] = sy_pll;
        link_state[1] = sy_absent;
        link_state[0] = sy_settled;

        // Strap taken only once s2 holds a real pin sample, not its reset zero
        if (!st_q.strap_taken) begin
            if (st_q.rst_sync == 2'h2) begin
                st_d.strap_taken = 1'b1;
                st_d.bridge[`BAL_BC_AUX_EN] = sy_strap;
            end else begin
                st_d.rst_sync = st_q.rst_sync + 2'h1;
            end
        end

        // Change detection on toggle levels; both banks have equal latency
        ev_now[EV_TYPE] = sy_type_tgl;
        ev_now[EV_AIF] = ev_sync2[2];
        ev_now[EV_AVI] = ev_sync2[1];
        ev_now[EV_ACR] = ev_sync2[0];
        ev_chg = ev_now ^ st_q.ev_prev;
        st_d.ev_prev = ev_now;

        ev_en[EV_TYPE] = st_q.audio[`BAL_AS_RST_TYPE];
        ev_en[EV_AIF] = st_q.audio[`BAL_AS_RST_AIF];
        ev_en[EV_AVI] = st_q.audio[`BAL_AS_RST_AVI];
        ev_en[EV_ACR] = st_q.audio[`BAL_AS_RST_ACR];
        st_d.fifo_rst = |(ev_chg & ev_en);

        link_rise = link_state[7] & ~st_q.ready_prev;
        link_fall = ~link_state[7] & st_q.ready_prev;
        clk_loss = link_state[1] & ~st_q.clk_absent_prev;
        st_d.ready_prev = link_state[7];
        st_d.clk_absent_prev = link_state[1];

        irq_set = '0;
        irq_set[`BAL_IRQ_FIFO_RST] = st_d.fifo_rst;
        irq_set[`BAL_IRQ_LINK_UP] = link_rise;
        irq_set[`BAL_IRQ_LINK_DOWN] = link_fall;
        irq_set[`BAL_IRQ_CLK_LOST] = clk_loss;
        irq_clr = '0;

        if (reg_wr_i) begin
            if (hit_bc) begin
                st_d.bridge = reg_wdata_i & `BAL_BC_MASK;
            end else if (hit_as) begin
                st_d.audio = reg_wdata_i & `BAL_AS_MASK;
            end else if (hit_is) begin
                irq_clr = reg_wdata_i[`BAL_IRQ_W-1:0];
            end else if (hit_im) begin
                st_d.irq_msk = reg_wdata_i[`BAL_IRQ_W-1:0];
            end else if (hit_ls) begin
                // Read-only status keeps its live value
                st_d.rdata = st_d.rdata;
            end
        end

        // Read data stand for one cycle only, zero otherwise
        st_d.rdata = 8'h00;
        if (reg_rd_i) begin
            if (hit_bc) begin
                st_d.rdata = st_q.bridge;
            end else if (hit_as) begin
                st_d.rdata = st_q.audio;
            end else if (hit_ls) begin
                st_d.rdata = link_state;
            end else if (hit_is) begin
                st_d.rdata = {4'h0, st_q.irq_sts};
            end else if (hit_im) begin
                st_d.rdata = {4'h0, st_q.irq_msk};
            end
        end

        // Set wins over a simultaneous clear, so no event is lost
        for (int b = 0; b < `BAL_IRQ_W; b++) begin
            st_d.irq_sts[b] = irq_set[b] | (st_q.irq_sts[b] & ~irq_clr[b]);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1_q <= 3'h0;
            ev_s2_q <= 3'h0;
        end else begin
            ev_s1_q <= {audio_infoframe_tgl_i, video_infoframe_tgl_i, clock_regen_tgl_i};
            ev_s2_q <= ev_s1_q;
        end
    end
    assign ev_sync2 = ev_s2_q;

    // All state leaves reset together, two edges after the pin releases
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q.rst_sync <= 2'h0;
            st_q.strap_taken <= 1'b0;
            st_q.bridge <= `BAL_BC_RESET;
            st_q.audio <= `BAL_AS_RESET;
            st_q.s1 <= '0;
            st_q.s2 <= '0;
            st_q.ev_prev <= 4'h0;
            st_q.fifo_rst <= 1'b0;
            st_q.irq_sts <= '0;
            st_q.irq_msk <= '0;
            st_q.ready_prev <= 1'b0;
            st_q.clk_absent_prev <= 1'b0;
            st_q.rdata <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o = st_q.rdata;
    assign tdm_audio_en_o = st_q.bridge[`BAL_BC_TDM_EN];
    assign local_audio_sel_o = st_q.bridge[`BAL_BC_SRC_SEL];
    assign aux_audio_en_o = st_q.bridge[`BAL_BC_AUX_EN];
    assign tdm_to_parallel_en_o = st_q.audio[`BAL_AS_TDM_PAR];
    assign converter_clk_sel_o = st_q.audio[`BAL_AS_TDM_PAR];
    // Embedded audio to I2S pins only while embedded source chosen
    assign i2s_out_en_o = st_q.audio[`BAL_AS_I2S_OUT] & ~st_q.bridge[`BAL_BC_SRC_SEL];
    assign audio_fifo_reset_o = st_q.fifo_rst;
    assign irq_o = |(st_q.irq_sts & st_q.irq_msk);

endmodule : bal_regs

/* tb/bal_far_side.sv */
/* Far-side model: input status levels and change toggles. Assumes one clock. */
`timescale 1ns/100ps
module bal_far_side (
    input wire logic clk_i,
    input wire logic [9:0] st_i,
    input wire logic [3:0] evt_i,
    output logic [9:0] pins_o,
    output logic [3:0] tgl_o
);
    initial tgl_o = '0;
    assign pins_o = st_i;
    // Each event flips a level, as the change inputs expect
    always @(posedge clk_i) tgl_o <= tgl_o ^ evt_i;
endmodule : bal_far_side

/* tb/bal_checker.sv */
/* Port checker for bal_regs. Assumes the register map of bal_params.svh. */
`timescale 1ns/100ps
`include "bal_params.svh"
module bal_checker (
    input wire logic sys_clk_i, arst_n_i, reg_wr_i, reg_rd_i, audio_fifo_reset_o, i2s_out_en_o,
    input wire logic [7:0] reg_addr_i,
    input wire bal_pkg::bal_byte_t reg_wdata_i, reg_rdata_o,
    input wire logic tdm_audio_en_o, local_audio_sel_o, aux_audio_en_o, tdm_to_parallel_en_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_bc; reg_wr_i && reg_addr_i == `BAL_ADDR_BRIDGE_CONTROL; endsequence
    sequence s_as; reg_wr_i && reg_addr_i == `BAL_ADDR_AUDIO_SETTINGS; endsequence
    sequence s_ls; reg_rd_i && reg_addr_i == `BAL_ADDR_LINK_STATE; endsequence
    property p_tdm; s_bc |=> tdm_audio_en_o == $past(reg_wdata_i[2]); endproperty
    a_tdm: assert property (p_tdm) else $error("tdm");
    property p_src; s_bc |=> local_audio_sel_o == $past(reg_wdata_i[1]); endproperty
    a_src: assert property (p_src) else $error("src");
    property p_aux; s_bc |=> aux_audio_en_o == $past(reg_wdata_i[0]); endproperty
    a_aux: assert property (p_aux) else $error("aux");
    property p_par; s_as |=> tdm_to_parallel_en_o == $past(reg_wdata_i[7]); endproperty
    a_par: assert property (p_par) else $error("par");
    property p_i2s; i2s_out_en_o |-> !local_audio_sel_o; endproperty
    a_i2s: assert property (p_i2s) else $error("i2s");
    property p_fifo; audio_fifo_reset_o |=> !audio_fifo_reset_o; endproperty
    a_fifo: assert property (p_fifo) else $error("fifo");
    property p_tx; s_ls |=> !reg_rdata_o[6] || reg_rdata_o[3]; endproperty
    a_tx: assert property (p_tx) else $error("tx");
    property p_mode; s_ls |=> reg_rdata_o[6] || reg_rdata_o[5:4] == 2'b00; endproperty
    a_mode: assert property (p_mode) else $error("mode");
endmodule : bal_checker
bind bal_regs bal_checker i_bal_checker (.*);

/* tb/bal_regs_tb.sv */
/* Testbench of bal_regs. Assumes the far-side model and the checker bound in. */
`timescale 1ns/100ps
`include "bal_params.svh"
module bal_regs_tb;
    import bal_pkg::*;
    logic sys_clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, strap_select_zero_i = 1;
    logic audio_fifo_reset_o, irq_o, seen;
    logic [7:0] reg_addr_i = 0;
    bal_byte_t reg_wdata_i = 0, reg_rdata_o;
    logic [9:0] st = 0, p;
    logic [3:0] evt = 0, t;
    logic [5:0] o;
    int err_count = 0, checks = 0;
    initial forever #50 sys_clk_i = ~sys_clk_i;
    bal_far_side i_bal_far_side (.clk_i(sys_clk_i), .st_i(st), .evt_i(evt), .pins_o(p), .tgl_o(t));
    bal_regs i_bal_regs (.*, .downstream_ready_i(p[9]), .serial_tx_on_i(p[8]), .remote_locked_i(p[7]),
        .mode_correct_i(p[6]), .serial_port_mode_i(p[5:4]), .input_symbols_recovered_i(p[3]),
        .input_pll_locked_i(p[2]), .input_clock_absent_i(p[1]), .input_frequency_settled_i(p[0]),
        .audio_type_tgl_i(t[0]), .audio_infoframe_tgl_i(t[1]), .video_infoframe_tgl_i(t[2]),
        .clock_regen_tgl_i(t[3]), .tdm_audio_en_o(o[5]), .local_audio_sel_o(o[4]), .aux_audio_en_o(o[3]),
        .tdm_to_parallel_en_o(o[2]), .converter_clk_sel_o(o[1]), .i2s_out_en_o(o[0]));
    task automatic chk(input string n, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, d);
        @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge sys_clk_i) reg_wr_i <= 0;
        @(negedge sys_clk_i);
    endtask : wreg
    task automatic rchk(input logic [7:0] a, e);
        @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge sys_clk_i) reg_rd_i <= 0;
        #1 chk($sformatf("reg %h", a), reg_rdata_o, e);
    endtask : rchk
    task automatic t_reset;
        rchk(`BAL_ADDR_AUDIO_SETTINGS, `BAL_AS_RESET);
        rchk(`BAL_ADDR_LINK_STATE, `BAL_LS_RESET);
        rchk(`BAL_ADDR_BRIDGE_CONTROL, 8'h01);
        rchk(8'h70, 8'h00);
    endtask : t_reset
    task automatic t_controls;
        for (int i = 0; i < 3; i++) begin
            wreg(`BAL_ADDR_BRIDGE_CONTROL, 8'h01 << i);
            chk("bridge", {5'h0, o[5:3]}, 8'h01 << i);
        end
        wreg(`BAL_ADDR_AUDIO_SETTINGS, 8'hc0);
        chk("audio", {5'h0, o[2:0]}, 8'h07);
        wreg(`BAL_ADDR_BRIDGE_CONTROL, 8'h02);
        chk("audio", {5'h0, o[2:0]}, 8'h06);
    endtask : t_controls
    task automatic t_status;
        @(posedge sys_clk_i) st <= 10'h3ef;
        repeat (4) @(posedge sys_clk_i);
        rchk(`BAL_ADDR_LINK_STATE, 8'hef);
        wreg(`BAL_ADDR_LINK_STATE, 8'h00);
        rchk(`BAL_ADDR_LINK_STATE, 8'hef);
        @(posedge sys_clk_i) st <= 10'h3e7;
        repeat (4) @(posedge sys_clk_i);
        rchk(`BAL_ADDR_LINK_STATE, 8'h87);
    endtask : t_status
    task automatic t_fifo;
        for (int k = 0; k < 5; k++) begin
            wreg(`BAL_ADDR_AUDIO_SETTINGS, 8'h08 >> k);
            @(posedge sys_clk_i) evt <= (k < 4) ? 4'h1 << k : 4'hf;
            @(posedge sys_clk_i) evt <= 0;
            seen = 0;
            repeat (6) @(negedge sys_clk_i) seen |= audio_fifo_reset_o;
            chk("fifo", seen, k < 4);
        end
        chk("irq", irq_o, 0);
        wreg(`BAL_ADDR_IRQ_MASK, 8'h01);
        @(negedge sys_clk_i) chk("irq", irq_o, 1);
        rchk(`BAL_ADDR_IRQ_STATUS, 8'h0b);
        wreg(`BAL_ADDR_IRQ_STATUS, 8'h01);
        @(negedge sys_clk_i) chk("irq", irq_o, 0);
    endtask : t_fifo
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        #400000;
        err_count++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge sys_clk_i);
        arst_n_i <= 1;
        repeat (5) @(posedge sys_clk_i);
        t_reset;
        t_controls;
        t_status;
        t_fifo;
        finish_test;
    end
endmodule : bal_regs_tb
